// File: src/low_voltage_monitor_ctrl.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// - The undervoltage status bit is read-only and writes to it are ignored.
// - In full performance operation the status bit goes to 1 when the analog supply is low.
// - The status bit returns to 0 only once the supply rises above the release level; the code also clears it whenever it leaves full performance operation.
// - In reduced power or shutdown operation the status bit reads as 0.
// - The interrupt is requested while the change flag is set and its enable is 1.
// - Every rising or falling change of the status bit sets the change flag.
// - Writing 1 clears the change flag, writing 0 leaves it alone.
// - Entering reduced power operation does not clear the change flag.
// - Detection and status updates run only in full performance operation.
// - The power-up reset output stays high until the core supply passes its level.
// - The power-up reset works in every operating mode.
// - The core reset asserts below its assert level and releases above its release level.
// - The core reset acts only in full performance operation.
// - Shutdown operation is entered while the regulator enable input is low.
// - Reduced power operation is chosen while the processor is stopped.
module low_voltage_monitor_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire vreg_ctrl_pkg::avl_req_type avl_req,
  output vreg_ctrl_pkg::avl_rsp_type avl_rsp,
  input wire vreg_ctrl_pkg::analog_type analog_in,
  input wire logic regulator_enable_in,
  input wire logic cpu_stop,
  output logic power_up_reset,
  output logic core_undervolt_reset,
  output logic undervolt_interrupt
);
  import vreg_ctrl_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    mode_type mode;
    logic uv_status;
    logic core_latch;
    logic core_reset;
    logic por;
    logic ack;
    logic [DATA_W-1:0] readdata;
  } ctrl_state_type;

  ctrl_state_type st_r;
  ctrl_state_type st_nxt;

  analog_type ana_s;
  logic en_s;
  logic [EVENT_N-1:0] irq_status;
  logic [EVENT_N-1:0] irq_enable;
  logic [EVENT_N-1:0] evt_set;
  logic [EVENT_N-1:0] evt_clr;
  logic [EVENT_N-1:0] en_we;
  logic [EVENT_N-1:0] en_wd;
  logic wr_take;
  logic rd_take;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Two thresholds give hysteresis; between them the level holds
  function automatic logic hyst(input logic cur, input logic below, input logic above);
    logic res;
    res = cur;
    if (below) begin
      res = 1'b1;
    end else if (above) begin
      res = 1'b0;
    end
    return res;
  endfunction

  function automatic logic [CTRL_W-1:0] ctrl_image(input logic sts, input logic en,
                                                   input logic flag);
    logic [CTRL_W-1:0] v;
    v = '0;
    v[BIT_UV_STATUS] = sts;
    v[BIT_UV_IRQ_ENABLE] = en;
    v[BIT_UV_CHANGE_FLAG] = flag;
    return v;
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // The stop request is same-clock logic and needs none
  sync_two_stage #(.WIDTH(ANALOG_W + 1)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({analog_in, regulator_enable_in}),
    .sync_out({ana_s, en_s})
  );

  // ------------------------------------------------------------
  // Bus slave: one wait state on every access
  // ------------------------------------------------------------
  assign wr_take = avl_req.write & st_r.ack;
  assign rd_take = avl_req.read & ~st_r.ack;
  assign avl_rsp.waitrequest = (avl_req.read | avl_req.write) & ~st_r.ack;
  assign avl_rsp.readdata = st_r.readdata;

  // ------------------------------------------------------------
  // Interrupt glue
  // ------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_clr = '0;
    en_we = '0;
    en_wd = '0;
    evt_set[EVT_UV_CHANGE] = st_nxt.uv_status ^ st_r.uv_status;
    evt_set[EVT_CORE_RESET] = st_nxt.core_reset & ~st_r.core_reset;
    if (wr_take) begin
      if (avl_req.address == OFS_CTRL_STATUS) begin
        evt_clr[EVT_UV_CHANGE] = avl_req.writedata[BIT_UV_CHANGE_FLAG];
        en_we[EVT_UV_CHANGE] = 1'b1;
        en_wd[EVT_UV_CHANGE] = avl_req.writedata[BIT_UV_IRQ_ENABLE];
      end else if (avl_req.address == OFS_IRQ_CLEAR) begin
        evt_clr = avl_req.writedata[EVENT_N-1:0];
      end else if (avl_req.address == OFS_IRQ_ENABLE) begin
        en_we = '1;
        en_wd = avl_req.writedata[EVENT_N-1:0];
      end
    end
  end

  sticky_irq #(.N(EVENT_N)) u_irq (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .set_evt(evt_set),
    .clr(evt_clr),
    .en_we(en_we),
    .en_wd(en_wd),
    .status(irq_status),
    .enable(irq_enable),
    .irq(undervolt_interrupt)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Operating mode
    if (!en_s) begin
      st_nxt.mode = MODE_SHUTDOWN;
    end else if (cpu_stop) begin
      st_nxt.mode = MODE_REDUCED;
    end else begin
      st_nxt.mode = MODE_FULL;
    end
    // Low-voltage detection; the detector sleeps outside full mode
    if (st_r.mode == MODE_FULL) begin
      st_nxt.uv_status = hyst(st_r.uv_status, ana_s.analog_below_assert,
                              ana_s.analog_above_deassert);
      st_nxt.core_latch = hyst(st_r.core_latch, ana_s.core_below_reset_assert,
                               ana_s.core_above_reset_release);
    end else begin
      st_nxt.uv_status = 1'b0;
      st_nxt.core_latch = 1'b0;
    end
    st_nxt.core_reset = st_nxt.core_latch;
    // Power-up reset ignores the mode on purpose
    st_nxt.por = ~ana_s.core_above_power_up_release;
    // Bus
    st_nxt.ack = (avl_req.read | avl_req.write) & ~st_r.ack;
    if (rd_take) begin
      st_nxt.readdata = '0;
      if (avl_req.address == OFS_CTRL_STATUS) begin
        st_nxt.readdata[CTRL_W-1:0] = ctrl_image(st_r.uv_status, irq_enable[EVT_UV_CHANGE],
                                                 irq_status[EVT_UV_CHANGE]);
      end else if (avl_req.address == OFS_IRQ_STATUS) begin
        st_nxt.readdata[EVENT_N-1:0] = irq_status;
      end else if (avl_req.address == OFS_IRQ_ENABLE) begin
        st_nxt.readdata[EVENT_N-1:0] = irq_enable;
      end else if (avl_req.address == OFS_MODE) begin
        st_nxt.readdata[1:0] = st_r.mode;
      end
    end
    // Status bit has no write path at all
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r.mode <= MODE_SHUTDOWN;
      st_r.uv_status <= RST_UV_STATUS;
      st_r.core_latch <= RST_CORE_RESET;
      st_r.core_reset <= RST_CORE_RESET;
      st_r.por <= RST_POWER_UP_RESET;
      st_r.ack <= 1'b0;
      st_r.readdata <= RST_READDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign power_up_reset = st_r.por;
  assign core_undervolt_reset = st_r.core_reset;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic flag;
  assign flag = irq_status[EVT_UV_CHANGE];

  sequence s_ctrl_write_status;
    wr_take && avl_req.address == OFS_CTRL_STATUS;
  endsequence

  sequence s_flag_cleared;
    wr_take && (avl_req.address == OFS_CTRL_STATUS &&
      avl_req.writedata[BIT_UV_CHANGE_FLAG] || avl_req.address == OFS_IRQ_CLEAR &&
      avl_req.writedata[EVT_UV_CHANGE]);
  endsequence

  property p_status_ro;
    s_ctrl_write_status ##0 (st_r.mode == MODE_FULL && !ana_s.analog_below_assert &&
      !ana_s.analog_above_deassert) |=> $stable(st_r.uv_status);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status bit took a write");

  property p_status_sets;
    (st_r.mode == MODE_FULL && ana_s.analog_below_assert) |=> st_r.uv_status;
  endproperty
  a_status_sets: assert property (p_status_sets) else $error("status did not set");

  property p_status_hyst;
    (st_r.mode == MODE_FULL && st_r.uv_status && !ana_s.analog_below_assert &&
      !ana_s.analog_above_deassert) |=> st_r.uv_status;
  endproperty
  a_status_hyst: assert property (p_status_hyst) else $error("status left the band");

  property p_status_zero;
    (st_r.mode != MODE_FULL) |=> !st_r.uv_status;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("status set outside full");

  property p_irq_level;
    (flag && irq_enable[EVT_UV_CHANGE]) |-> undervolt_interrupt;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

  property p_change_sets_flag;
    $changed(st_r.uv_status) |-> flag;
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag) else $error("flag not set");

  property p_flag_clear_cause;
    $fell(flag) |-> $past(wr_take && evt_clr[EVT_UV_CHANGE]);
  endproperty
  a_flag_clear_cause: assert property (p_flag_clear_cause) else $error("flag lost");

  property p_flag_kept;
    (flag && st_nxt.mode == MODE_REDUCED && !evt_clr[EVT_UV_CHANGE]) |=> flag;
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag cleared on mode entry");

  property p_por_follows;
    ana_s.core_above_power_up_release [*2] |-> ##1 !power_up_reset;
  endproperty
  a_por_follows: assert property (p_por_follows) else $error("power-up reset stuck");

  property p_por_any_mode;
    (!ana_s.core_above_power_up_release && st_r.mode == MODE_SHUTDOWN) |=> power_up_reset;
  endproperty
  a_por_any_mode: assert property (p_por_any_mode) else $error("power-up reset gated");

  property p_core_reset_gate;
    (st_r.mode != MODE_FULL) |=> !core_undervolt_reset;
  endproperty
  a_core_reset_gate: assert property (p_core_reset_gate) else $error("core reset leak");

  property p_shutdown;
    !en_s |=> st_r.mode == MODE_SHUTDOWN;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");

  property p_reduced;
    (en_s && cpu_stop) |=> st_r.mode == MODE_REDUCED;
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced mode not entered");

  property p_bus_answer;
    $rose(avl_req.read) |-> avl_rsp.waitrequest ##1 !avl_rsp.waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("read answer late");

  property p_write_answer;
    $rose(avl_req.write) |-> avl_rsp.waitrequest ##1 !avl_rsp.waitrequest;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");

  property p_readdata_stands;
    !rd_take |=> $stable(avl_rsp.readdata);
  endproperty
  a_readdata_stands: assert property (p_readdata_stands) else $error("read data moved");

  property p_flag_clears;
    s_flag_cleared ##0 !evt_set[EVT_UV_CHANGE] |=> !flag;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared");

  property p_flag_zero_write;
    s_ctrl_write_status ##0 (flag && !avl_req.writedata[BIT_UV_CHANGE_FLAG]) |=> flag;
  endproperty
  a_flag_zero_write: assert property (p_flag_zero_write) else $error("flag lost on 0");

  property p_status_release;
    (st_r.mode == MODE_FULL && !ana_s.analog_below_assert && ana_s.analog_above_deassert)
      |=> !st_r.uv_status;
  endproperty
  a_status_release: assert property (p_status_release) else $error("status stuck");

  property p_detect_idle;
    (st_r.mode != MODE_FULL && !st_r.uv_status) |-> !evt_set[EVT_UV_CHANGE];
  endproperty
  a_detect_idle: assert property (p_detect_idle) else $error("detector active");

  property p_core_assert;
    (st_r.mode == MODE_FULL && ana_s.core_below_reset_assert) |=> core_undervolt_reset;
  endproperty
  a_core_assert: assert property (p_core_assert) else $error("no core reset");

  property p_core_release;
    (st_r.mode == MODE_FULL && !ana_s.core_below_reset_assert &&
      ana_s.core_above_reset_release) |=> !core_undervolt_reset;
  endproperty
  a_core_release: assert property (p_core_release) else $error("core reset stuck");

  property p_core_event;
    $rose(core_undervolt_reset) |-> irq_status[EVT_CORE_RESET];
  endproperty
  a_core_event: assert property (p_core_event) else $error("core event lost");

  property p_por_high;
    !ana_s.core_above_power_up_release |=> power_up_reset;
  endproperty
  a_por_high: assert property (p_por_high) else $error("power-up reset low");

  property p_full_mode;
    (en_s && !cpu_stop) |=> st_r.mode == MODE_FULL;
  endproperty
  a_full_mode: assert property (p_full_mode) else $error("full mode not entered");

endmodule

// File: src/sticky_irq.sv
`timescale 1ns/1ps
module sticky_irq #(
  parameter int N = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [N-1:0] set_evt,
  input wire logic [N-1:0] clr,
  input wire logic [N-1:0] en_we,
  input wire logic [N-1:0] en_wd,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  import vreg_ctrl_pkg::*;

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
  } irq_state_type;

  irq_state_type st_r;
  irq_state_type st_nxt;

  if (N < 1 || N > EVENT_N) begin : g_bad_n
    $error("sticky_irq supports 1 to EVENT_N events");
  end

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      st_nxt.status[i] = set_evt[i] | (st_r.status[i] & ~clr[i]);
      st_nxt.enable[i] = en_we[i] ? en_wd[i] : st_r.enable[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r.status <= RST_IRQ_STATUS[N-1:0];
      st_r.enable <= RST_IRQ_ENABLE[N-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign enable = st_r.enable;
  assign irq = |(st_r.status & st_r.enable);

endmodule

// File: src/sync_two_stage.sv
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import vreg_ctrl_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_two_stage needs WIDTH of at least one");
  end

  // First stage feeds only the second stage
  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule

// File: src/vreg_ctrl_pkg.sv
package vreg_ctrl_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_MODE = 5'h10;

  // ------------------------------------------------------------
  // Field positions of regulator_control_status (8 bits wide)
  // ------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int BIT_UV_STATUS = 0;
  localparam int BIT_UV_IRQ_ENABLE = 1;
  localparam int BIT_UV_CHANGE_FLAG = 2;

  // ------------------------------------------------------------
  // Event bits of the interrupt status, clear and enable registers
  // ------------------------------------------------------------
  localparam int EVENT_N = 2;
  localparam int EVT_UV_CHANGE = 0;
  localparam int EVT_CORE_RESET = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic RST_UV_STATUS = 1'b0;
  localparam logic RST_POWER_UP_RESET = 1'b1;
  localparam logic RST_CORE_RESET = 1'b0;
  localparam logic [EVENT_N-1:0] RST_IRQ_STATUS = 2'h0;
  localparam logic [EVENT_N-1:0] RST_IRQ_ENABLE = 2'h0;
  localparam logic [DATA_W-1:0] RST_READDATA = 32'h0000_0000;

  // ------------------------------------------------------------
  // Synchroniser depth
  // ------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FULL,
    MODE_REDUCED,
    MODE_SHUTDOWN
  } mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
  } avl_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avl_rsp_type;

  // Comparator outputs, asynchronous to sys_clk
  typedef struct packed {
    logic analog_below_assert;
    logic analog_above_deassert;
    logic core_below_reset_assert;
    logic core_above_reset_release;
    logic core_above_power_up_release;
  } analog_type;

  localparam int ANALOG_W = $bits(analog_type);

endpackage

// File: test/cpu_side_model.sv
`timescale 1ns/1ps
module cpu_side_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic stop_req,
  input wire logic undervolt_interrupt,
  input wire logic power_up_reset,
  input wire logic core_undervolt_reset,
  output logic cpu_stop,
  output logic [7:0] irq_rises
);
  logic irq_r;
  // ------------------------------------------------------------
  // Processor stop and interrupt intake
  // ------------------------------------------------------------
  // A processor held in reset cannot enter stop; once stopped it stays until stop is withdrawn
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cpu_stop <= 1'b0;
      irq_r <= 1'b0;
      irq_rises <= 8'h00;
    end else begin
      cpu_stop <= stop_req & (cpu_stop | (~power_up_reset & ~core_undervolt_reset));
      irq_r <= undervolt_interrupt;
      if (undervolt_interrupt & ~irq_r) begin
        irq_rises <= irq_rises + 8'h01;
      end
    end
  end
endmodule

// File: test/low_voltage_monitor_ctrl_tb.sv
`timescale 1ns/1ps
module low_voltage_monitor_ctrl_tb;
  import vreg_ctrl_pkg::*;
  logic sys_clk, nrst, en_pin, stop_req, cpu_stop, pur, cur, irq, st;
  logic [7:0] irq_rises;
  avl_req_type req;
  avl_rsp_type rsp;
  analog_type ana;
  int mismatches, compares, cycles, seed_word;

  low_voltage_monitor_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .avl_req(req),
    .avl_rsp(rsp), .analog_in(ana), .regulator_enable_in(en_pin), .cpu_stop(cpu_stop),
    .power_up_reset(pur), .core_undervolt_reset(cur), .undervolt_interrupt(irq));
  cpu_side_model cpu (.sys_clk(sys_clk), .nrst(nrst), .stop_req(stop_req),
    .undervolt_interrupt(irq), .power_up_reset(pur), .core_undervolt_reset(cur),
    .cpu_stop(cpu_stop), .irq_rises(irq_rises));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Avalon master
  // ------------------------------------------------------------
  // Waitrequest and read data are taken at the rising edge; only the hang guard ends a wait
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    @(posedge sys_clk);
    req.address <= a;
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= wd;
    @(posedge sys_clk);
    while (rsp.waitrequest !== 1'b0) begin
      @(posedge sys_clk);
    end
    rd = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] x;
    acc(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    acc(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask

  // One comparator step with the interrupt enabled; hysteresis worked out here
  task automatic step(input logic b, input logic a);
    logic prev;
    logic chg;
    prev = st;
    @(posedge sys_clk);
    ana.analog_below_assert <= b;
    ana.analog_above_deassert <= a;
    st = b ? 1'b1 : (a ? 1'b0 : st);
    chg = (st != prev);
    repeat (4) @(posedge sys_clk);
    rdc(OFS_CTRL_STATUS, {29'h0, chg, 1'b1, st});
    rdc(OFS_IRQ_STATUS, {31'h0, chg});
    @(negedge sys_clk);
    chk({31'h0, irq}, {31'h0, chg});
    wr(OFS_CTRL_STATUS, 32'h2);
    rdc(OFS_CTRL_STATUS, {29'h0, chg, 1'b1, st});
    wr(OFS_CTRL_STATUS, 32'h6);
    rdc(OFS_CTRL_STATUS, {29'h0, 1'b0, 1'b1, st});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    compares = 0;
    cycles = 0;
    st = 1'b0;
    req = '0;
    ana = '0;
    en_pin = 1'b1;
    stop_req = 1'b0;
    nrst = 1'b0;
    seed_word = $urandom(14);
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk({31'h0, pur}, 32'h1);
    @(posedge sys_clk);
    ana.core_above_power_up_release <= 1'b1;
    repeat (5) @(negedge sys_clk);
    chk({31'h0, pur}, 32'h0);
    rdc(OFS_MODE, {30'h0, MODE_FULL});
    rdc(OFS_CTRL_STATUS, 32'h0);
    rdc(5'h14, 32'h0);
    wr(5'h14, 32'hFF);
    rdc(5'h14, 32'h0);
    wr(OFS_CTRL_STATUS, 32'h3);
    rdc(OFS_CTRL_STATUS, 32'h2);
    rdc(OFS_IRQ_ENABLE, 32'h1);
    // Corner cases first: set, hold in the band, both high, release
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      step(1'($urandom), 1'($urandom));
    end
    step(1'b0, 1'b1);
    chk({31'h0, irq_rises != 8'h00}, 32'h1);
    // Flag with the interrupt disabled
    wr(OFS_CTRL_STATUS, 32'h0);
    @(posedge sys_clk);
    ana.analog_below_assert <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_CTRL_STATUS, 32'h5);
    // Reduced power: status forced low, flag kept, core reset suppressed
    wr(OFS_IRQ_ENABLE, 32'h2);
    @(posedge sys_clk);
    stop_req <= 1'b1;
    ana.core_below_reset_assert <= 1'b1;
    ana.core_above_power_up_release <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({31'h0, cur}, 32'h0);
    chk({31'h0, pur}, 32'h1);
    rdc(OFS_MODE, {30'h0, MODE_REDUCED});
    rdc(OFS_CTRL_STATUS, 32'h4);
    @(posedge sys_clk);
    ana.core_above_power_up_release <= 1'b1;
    stop_req <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({31'h0, pur}, 32'h0);
    chk({31'h0, cur}, 32'h1);
    rdc(OFS_IRQ_STATUS, 32'h3);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    @(posedge sys_clk);
    ana.core_below_reset_assert <= 1'b0;
    ana.core_above_reset_release <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({31'h0, cur}, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h3);
    rdc(OFS_IRQ_STATUS, 32'h0);
    rdc(OFS_IRQ_ENABLE, 32'h2);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_CTRL_STATUS, 32'h1);
    // Shutdown: regulator enable low
    @(posedge sys_clk);
    en_pin <= 1'b0;
    repeat (6) @(negedge sys_clk);
    rdc(OFS_MODE, {30'h0, MODE_SHUTDOWN});
    rdc(OFS_CTRL_STATUS, 32'h4);
    chk({31'h0, pur}, 32'h0);
    @(posedge sys_clk);
    ana.core_above_power_up_release <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({31'h0, pur}, 32'h1);
    end_of_test();
  end
endmodule
